// *** rtl/stom_pkg.sv ***
// Purpose: shared constants and types for the safe torque off monitor
// Assumes: 200 MHz system clock
// Notes:   times kept in their own units, cycles per microsecond and microsecond tick counts derived
package stom_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned NOISE_TIME_US   = 500;       // 0.5 ms
  localparam int unsigned MISMATCH_TIME_S = 10;        // 10 seconds
  localparam int unsigned MONITOR_TIME_MS = 20;        // 20 ms bound on monitor update
  localparam int unsigned TICK_US_CYCLES  = CLK_HZ / 1_000_000;
  localparam int unsigned NOISE_US_TICKS  = NOISE_TIME_US + 1;
  localparam int unsigned MISMATCH_US     = MISMATCH_TIME_S * 1_000_000;
  localparam int unsigned MONITOR_US      = MONITOR_TIME_MS * 1000;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned ERR_W      = 32;
  localparam int unsigned TIMER_W    = 24;
  localparam int unsigned TICK_W     = 8;
  localparam int unsigned SYNC_DEPTH = 3;
  localparam logic [ERR_W-1:0] ERR_LIMIT_RESET = 32'h0004_0000;
  localparam logic [2:0] FAULT_CODE_NONE     = 3'h0;
  localparam logic [2:0] FAULT_CODE_LAG      = 3'h1;
  localparam logic [2:0] FAULT_CODE_MISMATCH = 3'h2;

  typedef enum logic [1:0] {
    STOM_RUN,
    STOM_HARD_BLOCK,
    STOM_BASEBLOCK
  } stom_state_t;

  // safe-off channel pair, each bit high when ON
  typedef struct packed {
    logic chan_b;
    logic chan_a;
  } stom_pair_t;

  typedef struct packed {
    logic       fault;
    logic [2:0] code;
  } stom_fault_t;

endpackage

// *** rtl/stom_input_filter.sv ***
// Purpose: synchroniser plus off-pulse rejection for one safe-off channel
// Assumes: raw_in is asynchronous, high means ON
// Notes:   an OFF shorter than the noise window is never reported
`timescale 1ns/100ps
module stom_input_filter
  import stom_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  // channel
  input  wire logic us_tick_in,
  input  wire logic raw_in,
  output logic      on_out
);

  logic [SYNC_DEPTH-1:0] sync;
  logic [TIMER_W-1:0]    off_cnt;
  wire                   agreed_off = (sync[1] == sync[2]) && !sync[2];
  wire                   agreed_on  = (sync[1] == sync[2]) && sync[2];

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sync    <= '1;
      off_cnt <= '0;
      on_out  <= 1'b1;
    end else begin
      sync <= {sync[SYNC_DEPTH-2:0], raw_in};
      if (agreed_on) begin
        off_cnt <= '0;
        on_out  <= 1'b1;
      end else if (agreed_off && us_tick_in) begin
        if (off_cnt >= TIMER_W'(NOISE_US_TICKS - 1)) begin
          on_out <= 1'b0;
        end else begin
          off_cnt <= off_cnt + 1'b1;
        end
      end
    end
  end

endmodule // stom_input_filter

// *** rtl/stom_top.sv ***
// Purpose: hard baseblock tracking, position error handling, fault and monitor outputs
// Assumes: safe-off pins high means ON; drive_on and position pulses from same-clock logic
// Notes:   faults latch until reset
//
// Function
// - enter hard baseblock when either safe-off input is OFF.
// - ignore OFF pulses of 0.5 ms or shorter as noise.
// - raise mismatch fault if inputs disagree for 10 seconds.
// - leave hard baseblock for baseblock only after drive-on is dropped.
// - in hard baseblock, clear position error per the clear select setting.
// - with select 1, keep accumulating error while references arrive.
// - raise lag overflow fault when accumulated error exceeds limit.
// - uncleared error moves the motor after baseblock and new drive-on.
// - with select 1, clear input in either block state clears error.
// - fault_out and fault_code_out are silent during hard baseblock; the lag and mismatch fault flags are not.
// - monitor output ON only when both safe-off inputs are OFF.
// - monitor output updates within 20 ms of any input change.
// - both inputs OFF shows the hard block display and blocks the motor.
// - report each safe-off input state on the monitor display item.
`timescale 1ns/100ps
module stom_top
  import stom_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  // safe-off pins, high means ON
  input  wire logic              safe_off_in_a,
  input  wire logic              safe_off_in_b,
  // drive control
  input  wire logic              drive_on_in,
  input  wire logic              error_clear_select_in,
  input  wire logic              error_clear_in,
  input  wire logic              pos_ref_pulse_in,
  input  wire logic              pos_ref_dir_in,
  input  wire logic              pos_fb_pulse_in,
  input  wire logic              pos_fb_dir_in,
  input  wire logic [ERR_W-1:0]  error_limit_in,
  // state and status
  output logic                   hard_baseblock_state_out,
  output logic                   baseblock_state_out,
  output logic                   motor_enable_out,
  output logic signed [ERR_W-1:0] position_error_out,
  output logic                   lag_overflow_fault_out,
  output logic                   safe_input_mismatch_fault_out,
  // pins back to the outside
  output logic                   fault_out,
  output logic [2:0]             fault_code_out,
  output logic                   safe_off_monitor_out,
  // operator display
  output logic                   hard_block_display_out,
  output stom_pair_t             safe_input_monitor_out
);

  // ****************************************
  // microsecond tick
  // ****************************************
  logic [TICK_W-1:0] tick_cnt;
  logic              us_tick;
  wire               tick_wrap = (tick_cnt == TICK_W'(TICK_US_CYCLES - 1));

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      tick_cnt <= '0;
      us_tick  <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
      us_tick  <= tick_wrap;
    end
  end

  // ****************************************
  // input conditioning
  // ****************************************
  stom_pair_t chan_on;

  stom_input_filter u_filt_a (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .us_tick_in (us_tick),
    .raw_in     (safe_off_in_a),
    .on_out     (chan_on.chan_a)
  );

  stom_input_filter u_filt_b (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .us_tick_in (us_tick),
    .raw_in     (safe_off_in_b),
    .on_out     (chan_on.chan_b)
  );

  // clear input is a pin too, so it gets the same three stages
  logic [SYNC_DEPTH-1:0] clr_sync;
  logic                  clr_level;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      clr_sync  <= '0;
      clr_level <= 1'b0;
    end else begin
      clr_sync <= {clr_sync[SYNC_DEPTH-2:0], error_clear_in};
      if (clr_sync[1] == clr_sync[2]) begin
        clr_level <= clr_sync[2];
      end
    end
  end

  // ****************************************
  // block state machine
  // ****************************************
  stom_state_t state;
  stom_state_t next_state;
  wire any_off  = !chan_on.chan_a || !chan_on.chan_b;
  wire both_off = !chan_on.chan_a && !chan_on.chan_b;
  wire in_hbb   = (state == STOM_HARD_BLOCK);
  wire in_bb    = (state == STOM_BASEBLOCK);

  always_comb begin
    next_state = state;
    case (state)
      STOM_RUN: begin
        if (any_off) begin
          next_state = STOM_HARD_BLOCK;
        end else if (!drive_on_in) begin
          next_state = STOM_BASEBLOCK;
        end
      end
      STOM_HARD_BLOCK: begin
        if (!any_off && !drive_on_in) begin
          next_state = STOM_BASEBLOCK;
        end
      end
      STOM_BASEBLOCK: begin
        if (any_off) begin
          next_state = STOM_HARD_BLOCK;
        end else if (drive_on_in) begin
          next_state = STOM_RUN;
        end
      end
      default: next_state = STOM_HARD_BLOCK;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= STOM_HARD_BLOCK;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // position error accumulator
  // ****************************************
  logic signed [ERR_W-1:0] pos_err;
  wire signed [ERR_W-1:0] ref_step = !pos_ref_pulse_in ? '0 :
                                     (pos_ref_dir_in ? -ERR_W'(1) : ERR_W'(1));
  wire signed [ERR_W-1:0] fb_step  = !pos_fb_pulse_in ? '0 :
                                     (pos_fb_dir_in ? -ERR_W'(1) : ERR_W'(1));
  // feedback is ignored only in hard baseblock; there, references pile up
  wire signed [ERR_W-1:0] next_err = pos_err + ref_step - (in_hbb ? '0 : fb_step);
  wire clear_auto = in_hbb && !error_clear_select_in;
  wire clear_pin  = error_clear_select_in && clr_level && (in_hbb || in_bb);
  wire signed [ERR_W-1:0] abs_err = next_err[ERR_W-1] ? -next_err : next_err;
  wire over_limit = $unsigned(abs_err) > error_limit_in;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pos_err <= '0;
    end else if (clear_auto || clear_pin) begin
      pos_err <= '0;
    end else begin
      pos_err <= next_err;
    end
  end

  // ****************************************
  // fault detection
  // ****************************************
  logic [TIMER_W-1:0] mis_cnt;
  logic               lag_fault;
  logic               mis_fault;
  wire                mismatch = chan_on.chan_a != chan_on.chan_b;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mis_cnt   <= '0;
      lag_fault <= 1'b0;
      mis_fault <= 1'b0;
    end else begin
      if (!mismatch) begin
        mis_cnt <= '0;
      end else if (us_tick) begin
        if (mis_cnt >= TIMER_W'(MISMATCH_US - 1)) begin
          mis_fault <= 1'b1;
        end else begin
          mis_cnt <= mis_cnt + 1'b1;
        end
      end
      if (!clear_auto && !clear_pin && over_limit) begin
        lag_fault <= 1'b1;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  wire stom_fault_t next_fault = '{fault: lag_fault || mis_fault,
                                   code:  lag_fault ? FAULT_CODE_LAG :
                                          (mis_fault ? FAULT_CODE_MISMATCH : FAULT_CODE_NONE)};

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      hard_baseblock_state_out      <= 1'b1;
      baseblock_state_out           <= 1'b0;
      motor_enable_out              <= 1'b0;
      position_error_out            <= '0;
      lag_overflow_fault_out        <= 1'b0;
      safe_input_mismatch_fault_out <= 1'b0;
      fault_out                     <= 1'b0;
      fault_code_out                <= FAULT_CODE_NONE;
      safe_off_monitor_out          <= 1'b0;
      hard_block_display_out        <= 1'b0;
      safe_input_monitor_out        <= '0;
    end else begin
      hard_baseblock_state_out      <= in_hbb;
      baseblock_state_out           <= in_bb;
      motor_enable_out              <= (state == STOM_RUN) && !any_off;
      position_error_out            <= pos_err;
      lag_overflow_fault_out        <= lag_fault;
      safe_input_mismatch_fault_out <= mis_fault;
      // fault_out and fault_code_out go quiet in hard baseblock so a safety stop is not read as a fault
      fault_out                     <= in_hbb ? 1'b0 : next_fault.fault;
      fault_code_out                <= in_hbb ? FAULT_CODE_NONE : next_fault.code;
      safe_off_monitor_out          <= both_off;
      hard_block_display_out        <= both_off;
      safe_input_monitor_out        <= chan_on;
    end
  end

endmodule // stom_top

// *** bench/stom_top_props.sv ***
// Purpose: port assertions for stom_top
// Assumes: one clock domain, synchronous reset
// Notes:   checks start two cycles after reset drops, once outputs leave reset values
`timescale 1ns/100ps
module stom_top_props
  import stom_pkg::*;
(
  // watched ports
  input wire logic                    sys_clk_in,
  input wire logic                    reset_in,
  input wire logic                    drive_on_in,
  input wire logic                    error_clear_select_in,
  input wire logic                    error_clear_in,
  input wire logic                    pos_ref_pulse_in,
  input wire logic                    pos_ref_dir_in,
  input wire logic                    pos_fb_pulse_in,
  input wire logic [ERR_W-1:0]        error_limit_in,
  input wire logic                    hard_baseblock_state_out,
  input wire logic                    baseblock_state_out,
  input wire logic                    motor_enable_out,
  input wire logic signed [ERR_W-1:0] position_error_out,
  input wire logic                    lag_overflow_fault_out,
  input wire logic                    fault_out,
  input wire logic [2:0]              fault_code_out,
  input wire logic                    safe_off_monitor_out,
  input wire stom_pair_t              safe_input_monitor_out
);
  // two stages: the reset pattern of the monitor pair is not a real input state
  logic [1:0] rst_d;
  wire logic  both_off = (safe_input_monitor_out == 2'b00);
  always_ff @(posedge sys_clk_in) rst_d <= {rst_d[0], reset_in};
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in || (rst_d != 2'b00));
  sequence s_hbb_exit;
    $fell(hard_baseblock_state_out);
  endsequence
  sequence s_drive_dropped;
    !$past(drive_on_in, 2) ##0 baseblock_state_out;
  endsequence
  AST_ANY_OFF: assert property (
    safe_input_monitor_out != 2'b11 |-> ##[0:2] hard_baseblock_state_out)
    else $error("off input without hard block");
  AST_LEAVE: assert property (s_hbb_exit |-> s_drive_dropped)
    else $error("hard block left without drive drop");
  AST_SEL0: assert property (
    (hard_baseblock_state_out && !error_clear_select_in)[*3] |-> position_error_out == '0)
    else $error("error kept with auto clear");
  AST_REF_STEP: assert property (
    pos_ref_pulse_in && !pos_ref_dir_in && !pos_fb_pulse_in && motor_enable_out &&
    !lag_overflow_fault_out |-> ##2 position_error_out == $past(position_error_out) + 1)
    else $error("reference pulse not counted");
  AST_LAG: assert property (
    !position_error_out[ERR_W-1] && $unsigned(position_error_out) > error_limit_in &&
    motor_enable_out |-> ##[0:2] lag_overflow_fault_out)
    else $error("overflow not flagged");
  AST_CLR_IN: assert property (
    (error_clear_select_in && error_clear_in &&
    (hard_baseblock_state_out || baseblock_state_out))[*8] |-> position_error_out == '0)
    else $error("clear input ignored");
  AST_SILENT: assert property (
    hard_baseblock_state_out && $past(hard_baseblock_state_out) |->
    !fault_out && fault_code_out == FAULT_CODE_NONE)
    else $error("fault pins driven in hard block");
  AST_MON_MAP: assert property (safe_off_monitor_out == both_off)
    else $error("monitor disagrees with inputs");
endmodule // stom_top_props
bind stom_top stom_top_props stom_top_props_inst (
  .sys_clk_in, .reset_in, .drive_on_in, .error_clear_select_in, .error_clear_in,
  .pos_ref_pulse_in, .pos_ref_dir_in, .pos_fb_pulse_in, .error_limit_in,
  .hard_baseblock_state_out, .baseblock_state_out, .motor_enable_out,
  .position_error_out, .lag_overflow_fault_out, .fault_out, .fault_code_out,
  .safe_off_monitor_out, .safe_input_monitor_out
);

// *** bench/stom_safety_unit.sv ***
// Purpose: safety unit and host reference source facing stom_top
// Assumes: guard and reference requests come from the bench
// Notes:   pins stay OFF until the monitor confirms both channels opened
`timescale 1ns/100ps
module stom_safety_unit
(
  // bench side
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  input  wire logic guard_open_in,
  input  wire logic noise_a_in,
  input  wire logic ref_req_in,
  input  wire logic ref_force_in,
  // drive side
  input  wire logic monitor_in,
  input  wire logic hard_block_in,
  output logic      pin_a_out,
  output logic      pin_b_out,
  output logic      ref_pulse_out
);
  logic pins_on;
  logic next_pins_on;
  assign next_pins_on = guard_open_in ? 1'b0 : (pins_on | monitor_in);
  always_ff @(posedge sys_clk_in) begin
    pins_on <= reset_in ? 1'b1 : next_pins_on;
  end
  assign pin_a_out = pins_on & ~noise_a_in;
  assign pin_b_out = pins_on;
  // force breaks the halt on purpose, to see references pile up in hard block
  assign ref_pulse_out = ref_req_in & (~hard_block_in | ref_force_in);
endmodule // stom_safety_unit

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for stom_top
// Assumes: 200 MHz clock, inputs change 1 ns after the edge
// Notes:   noise window is full length, so a guard cycle costs ~0.5 ms
`timescale 1ns/100ps
module tb_top;
  import stom_pkg::*;
  logic                    sys_clk_in = 1'b0;
  logic                    reset_in = 1'b1;
  logic                    drive_on_in = 1'b1;
  logic                    error_clear_select_in = 1'b0;
  logic                    error_clear_in = 1'b0;
  logic                    guard_open = 1'b0;
  logic                    noise_a = 1'b0;
  logic                    ref_req = 1'b0;
  logic                    ref_force = 1'b0;
  logic [ERR_W-1:0]        error_limit_in = 32'h0000_1000;
  logic                    safe_off_in_a, safe_off_in_b, pos_ref_pulse_in;
  logic                    hard_baseblock_state_out, baseblock_state_out, motor_enable_out;
  logic                    lag_overflow_fault_out, safe_input_mismatch_fault_out, fault_out;
  logic                    safe_off_monitor_out, hard_block_display_out;
  logic [2:0]              fault_code_out;
  logic signed [ERR_W-1:0] position_error_out;
  stom_pair_t              safe_input_monitor_out;
  int                      err_total = 0;
  int                      num_checks = 0;
  int                      cycles = 0;
  stom_top stom_top_inst (
    .sys_clk_in, .reset_in, .safe_off_in_a, .safe_off_in_b, .drive_on_in,
    .error_clear_select_in, .error_clear_in, .pos_ref_pulse_in,
    .pos_ref_dir_in(1'b0), .pos_fb_pulse_in(1'b0), .pos_fb_dir_in(1'b0),
    .error_limit_in, .hard_baseblock_state_out, .baseblock_state_out,
    .motor_enable_out, .position_error_out, .lag_overflow_fault_out,
    .safe_input_mismatch_fault_out, .fault_out, .fault_code_out,
    .safe_off_monitor_out, .hard_block_display_out, .safe_input_monitor_out
  );
  stom_safety_unit stom_safety_unit_inst (
    .sys_clk_in, .reset_in, .guard_open_in(guard_open), .noise_a_in(noise_a),
    .ref_req_in(ref_req), .ref_force_in(ref_force), .monitor_in(safe_off_monitor_out),
    .hard_block_in(hard_baseblock_state_out), .pin_a_out(safe_off_in_a),
    .pin_b_out(safe_off_in_b), .ref_pulse_out(pos_ref_pulse_in)
  );
  // ********
  // clock, timeout, shared tasks
  // ********
  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles = cycles + 1;
    if (cycles == 105_000) begin
      err_total = err_total + 1;
      summarize();
    end
  end
  task automatic summarize();
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic check(input logic [ERR_W-1:0] seen, input logic [ERR_W-1:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      ref_req = 1'b1;
      cyc(1);
      ref_req = 1'b0;
      cyc(1);
    end
    cyc(3);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_start();
    cyc(5);
    check(hard_baseblock_state_out, 1'b1);
    drive_on_in = 1'b0;
    cyc(3);
    check(baseblock_state_out, 1'b1);
    drive_on_in = 1'b1;
    error_clear_select_in = 1'b1;
    cyc(3);
    check(motor_enable_out, 1'b1);
    pulses(5);
    check(position_error_out, 32'h5);
  endtask
  task automatic t_noise();
    noise_a = 1'b1;
    cyc(1000);
    noise_a = 1'b0;
    cyc(20);
    check(hard_baseblock_state_out, 1'b0);
    check(safe_input_monitor_out, 2'b11);
    check(safe_input_mismatch_fault_out, 1'b0);
  endtask
  task automatic t_guard();
    guard_open = 1'b1;
    cyc(100_600);
    check(hard_baseblock_state_out, 1'b1);
    check(safe_off_monitor_out, 1'b1);
    check({hard_block_display_out, motor_enable_out}, 2'b10);
    check(safe_input_monitor_out, 2'b00);
    check({fault_out, fault_code_out}, 4'h0);
    check(lag_overflow_fault_out, 1'b1);
    pulses(3);
    check(position_error_out, 32'h9);
    ref_force = 1'b1;
    pulses(3);
    ref_force = 1'b0;
    check(position_error_out, 32'hc);
  endtask
  task automatic t_resume();
    guard_open = 1'b0;
    cyc(20);
    check(hard_baseblock_state_out, 1'b1);
    check({safe_off_monitor_out, safe_input_monitor_out}, 3'h3);
    drive_on_in = 1'b0;
    cyc(3);
    check(position_error_out, 32'hc);
    error_clear_in = 1'b1;
    cyc(10);
    check(position_error_out, 32'h0);
    error_clear_in = 1'b0;
    cyc(6);
    drive_on_in = 1'b1;
    cyc(3);
    check(motor_enable_out, 1'b1);
    check({fault_out, fault_code_out}, {1'b1, FAULT_CODE_LAG});
  endtask
  task automatic t_lag();
    error_limit_in = 32'h0000_0003;
    cyc(1);
    pulses(4);
    check({lag_overflow_fault_out, fault_out, fault_code_out}, {2'b11, FAULT_CODE_LAG});
  endtask
  initial begin
    cyc(10);
    reset_in = 1'b0;
    t_start();
    t_noise();
    t_lag();
    t_guard();
    t_resume();
    summarize();
  end
endmodule // tb_top
